// *** verilog/pbr_regulator.sv ***
// Pulse-balance counter and current command with per-PWM-pulse limit
// ==========================================================
// Overview of operation
// [R01] Count up on reference, down on feedback
// [R02] Count single pulse events, never rate
// [R03] Current command proportional to count
// [R04] Balanced pulses leave count unchanged
// [R05] Feedback pulse equals three degrees shaft
// [R06] Gain sets pulses to limit, 90..10
// [R07] Minimum gain: 1/60 full load per pulse
// [R08] Maximum gain: 1/10 limit per pulse
// [R09] Counter floors at zero, zero current
// [R10] Limit checked each PWM pulse, curtailed
// [R11] Current never exceeds 150 percent nameplate
// [R12] Limit setting linear 0 to 150 percent
// [R13] At limit clamp output, flag limit
// [R14] Operator sets gain mid-range typically
// [R15] Reference lost only while at limit
// [R16] 120 feedback pulses per motor revolution
// [R17] Digital reference applied immediately, no ramp
// [R18] Counter saturates at gain-selected count
// [R19] Simultaneous pulses leave counter unchanged
`timescale 1ns/100ps
module pbr_regulator
  import pbr_pkg::*;
#(
  parameter int unsigned CNT_WIDTH = CNT_W,
  parameter int unsigned GAIN_WIDTH = GAIN_W,
  parameter int unsigned LIM_WIDTH = LIM_W,
  parameter int unsigned CUR_WIDTH = CUR_W
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ref_pulse,      // One-cycle reference event
  input  wire logic                  fb_pulse,       // One-cycle motor feedback event
  input  wire logic [GAIN_WIDTH-1:0] gain_set,       // 0 = minimum gain
  input  wire logic [LIM_WIDTH-1:0]  limit_set,      // 0 = 0 %, all ones = 150 %
  input  wire logic                  pwm_start,      // One-cycle start of each PWM pulse
  input  wire logic [CUR_WIDTH-1:0]  cur_peak,       // Sensed output current within pulse
  output      logic [CUR_WIDTH-1:0]  cur_cmd,        // Commanded current
  output      logic                  pwm_gate,       // High while PWM pulse may conduct
  output      logic                  cur_limit,      // Current-limit indication
  output      logic [CNT_WIDTH-1:0]  pulse_count,    // Accumulated pulse difference
  output      logic [15:0]           fb_revs         // Whole revolutions seen
);
  // ==========================================================
  // Derived scale constants
  localparam int unsigned GMAX     = (1 << GAIN_WIDTH) - 1;
  localparam int unsigned LMAX     = (1 << LIM_WIDTH) - 1;
  localparam int unsigned SPAN     = PULSES_MIN_GAIN - PULSES_MAX_GAIN;
  localparam int unsigned REV_W    = 7;
  localparam logic [REV_W-1:0] REV_LAST = REV_W'(FB_PULSES_PER_REV - 1);

  // ==========================================================
  // Gain: pulses to reach limit, linear from 90 at min to 10 at max
  wire [GAIN_WIDTH+7:0] span_scaled = (GAIN_WIDTH+8)'(gain_set) * (GAIN_WIDTH+8)'(SPAN);
  wire [GAIN_WIDTH+7:0] span_drop   = span_scaled / (GAIN_WIDTH+8)'(GMAX);
  wire [CNT_WIDTH-1:0]  pulses_to_limit =
    CNT_WIDTH'(PULSES_MIN_GAIN) - CNT_WIDTH'(span_drop);                      // [R06]

  // ==========================================================
  // Limit level, linear 0..150 % of full load
  wire [CUR_WIDTH-1:0] limit_level;
  pbr_scale #(
    .A_W     (LIM_WIDTH),
    .B_W     (CUR_WIDTH),
    .OUT_W   (CUR_WIDTH),
    .DIVISOR (LMAX)
  ) u_limit_scale (
    .a (limit_set),
    .b (CUR_CEILING),
    .y (limit_level)
  );                                                                          // [R12]
  wire [CUR_WIDTH-1:0] limit_capped =
    (limit_level > CUR_CEILING) ? CUR_CEILING : limit_level;                  // [R11]

  // ==========================================================
  // Counter next value
  logic [CNT_WIDTH-1:0] count_q;
  logic [CNT_WIDTH-1:0] count_d;
  wire at_limit = (count_q >= pulses_to_limit);
  wire at_zero  = (count_q == CNT_RESET);
  wire inc      = ref_pulse & ~fb_pulse;                                      // [R19]
  wire dec      = fb_pulse & ~ref_pulse;                                      // [R19]

  // Each edge-free event moves one count, so only pulse number matters
  always_comb begin
    count_d = count_q;                                                        // [R04]
    if (inc && !at_limit) begin
      count_d = count_q + CNT_WIDTH'(1);                                      // [R01] [R02] [R17]
    end else if (inc && at_limit) begin
      count_d = pulses_to_limit;                                              // [R15] [R18]
    end else if (dec && !at_zero) begin
      count_d = count_q - CNT_WIDTH'(1);                                      // [R01]
    end else if (dec && at_zero) begin
      count_d = CNT_RESET;                                                    // [R09]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= CNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // ==========================================================
  // Current command: count * limit / pulses_to_limit, clamped at limit
  // Divider is combinational; fine at 40 MHz for these widths
  wire [CNT_WIDTH+CUR_WIDTH-1:0] cmd_prod = (CNT_WIDTH+CUR_WIDTH)'(count_q)
                                          * (CNT_WIDTH+CUR_WIDTH)'(limit_capped);
  wire [CNT_WIDTH+CUR_WIDTH-1:0] cmd_div  = (pulses_to_limit == '0) ? '0
    : cmd_prod / (CNT_WIDTH+CUR_WIDTH)'(pulses_to_limit);                     // [R03] [R07] [R08]
  wire [CUR_WIDTH-1:0] cmd_raw  = CUR_WIDTH'(cmd_div);
  wire [CUR_WIDTH-1:0] cmd_next = at_limit ? limit_capped
                                : (cmd_raw > limit_capped ? limit_capped : cmd_raw); // [R13] [R09]

  // ==========================================================
  // Per-PWM-pulse peak limiter
  logic pwm_gate_q;
  logic climit_q;
  logic [CUR_WIDTH-1:0] cmd_q;
  wire peak_hit = pwm_gate_q && (cur_peak >= limit_capped);                   // [R10]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_gate_q <= 1'b0;
      climit_q   <= 1'b0;
      cmd_q      <= '0;
    end else begin
      cmd_q <= cmd_next;
      if (pwm_start) begin
        pwm_gate_q <= (cmd_next != '0);                                       // [R09]
      end else if (peak_hit) begin
        pwm_gate_q <= 1'b0;                                                   // [R10]
      end
      climit_q <= at_limit | peak_hit;                                        // [R13]
    end
  end

  // ==========================================================
  // Revolution tally, purely informative
  logic [REV_W-1:0] rev_pos_q;
  logic [15:0]      revs_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rev_pos_q <= '0;
      revs_q    <= 16'h0000;
    end else if (fb_pulse) begin
      rev_pos_q <= (rev_pos_q == REV_LAST) ? '0 : rev_pos_q + REV_W'(1);      // [R05] [R16]
      if (rev_pos_q == REV_LAST) begin
        revs_q <= revs_q + 16'h0001;
      end
    end
  end

  assign cur_cmd     = cmd_q;
  assign pwm_gate    = pwm_gate_q;
  assign cur_limit   = climit_q;
  assign pulse_count = count_q;
  assign fb_revs     = revs_q;
endmodule // pbr_regulator

// *** verilog/pbr_pkg.sv ***
// Constants shared by the pulse-balance current regulator
package pbr_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned CNT_W       = 8;   // Counter range covers 90-pulse gain
  localparam int unsigned GAIN_W      = 8;   // Gain setting, 0 = minimum, max = maximum
  localparam int unsigned LIM_W       = 8;   // Limit setting, 0 = 0 %, max = 150 %
  localparam int unsigned CUR_W       = 12;  // Current words, full load = CUR_FULL_LOAD
  // ==========================================================
  // Gain end points (pulses to reach current limit)
  localparam int unsigned PULSES_MIN_GAIN = 90;
  localparam int unsigned PULSES_MAX_GAIN = 10;
  // ==========================================================
  // Current scale: full load current and 150 % ceiling
  localparam int unsigned CEIL_PERCENT    = 150;
  localparam logic [CUR_W-1:0] CUR_FULL_LOAD = 12'h3c0;  // 960 counts
  localparam logic [CUR_W-1:0] CUR_CEILING   = 12'h5a0;  // 150 % of full load
  // ==========================================================
  // Motor geometry
  localparam int unsigned FB_PULSES_PER_REV = 120;
  localparam int unsigned DEG_PER_PULSE     = 3;
  // ==========================================================
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
endpackage

// *** verilog/pbr_scale.sv ***
// Linear scaler: out = a * b / divisor, combinational
`timescale 1ns/100ps
module pbr_scale #(
  parameter int unsigned A_W     = 8,
  parameter int unsigned B_W     = 8,
  parameter int unsigned OUT_W   = 12,
  parameter int unsigned DIVISOR = 255
) (
  input  wire logic [A_W-1:0]   a,
  input  wire logic [B_W-1:0]   b,
  output      logic [OUT_W-1:0] y
);
  localparam int unsigned P_W = A_W + B_W;
  wire [P_W-1:0] prod = P_W'(a) * P_W'(b);
  wire [P_W-1:0] quot = prod / P_W'(DIVISOR);
  assign y = OUT_W'(quot);
endmodule // pbr_scale

// *** dv/pbr_motor.sv ***
// Motor-side model: pulse sources and sensed winding current
`timescale 1ns/100ps
module pbr_motor import pbr_pkg::*; (
  input  wire logic             clk,
  input  wire logic             pwm_gate,
  input  wire logic [1:0]       mode,       // Bit 0 reference on, bit 1 feedback on
  output      logic             ref_pulse,
  output      logic             fb_pulse,
  output      logic [CUR_W-1:0] cur_peak
);
  // Winding current builds only while the gate conducts
  initial begin
    ref_pulse = 1'b0;
    fb_pulse  = 1'b0;
    cur_peak  = 12'h000;
    forever begin
      @(negedge clk);
      ref_pulse = mode[0] & 1'($urandom_range(1));
      fb_pulse  = mode[1] & 1'($urandom_range(1));
      cur_peak  = pwm_gate ? cur_peak + 12'h0c8 : 12'h000;
    end
  end
endmodule // pbr_motor

// *** dv/pbr_chk.sv ***
// Port assertions for the regulator
`timescale 1ns/100ps
module pbr_chk import pbr_pkg::*; #(
  parameter int unsigned CNT_WIDTH = CNT_W, GAIN_WIDTH = GAIN_W, LIM_WIDTH = LIM_W, CUR_WIDTH = CUR_W
) (
  input wire logic                  clk, sys_rst, ref_pulse, fb_pulse, pwm_start, pwm_gate, cur_limit,
  input wire logic [GAIN_WIDTH-1:0] gain_set,
  input wire logic [LIM_WIDTH-1:0]  limit_set,
  input wire logic [CUR_WIDTH-1:0]  cur_peak, cur_cmd,
  input wire logic [CNT_WIDTH-1:0]  pulse_count,
  input wire logic [15:0]           fb_revs
);
  // Only the two end gains have exact pulse counts
  wire       gain_end = (gain_set == '0) || (&gain_set);
  wire [7:0] ptl      = (&gain_set) ? 8'h0a : 8'h5a;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_known; gain_end && $stable(gain_set); endsequence
  sequence s_trip; pwm_gate && !pwm_start && (&limit_set) && cur_peak >= CUR_CEILING; endsequence
  a_count_up: assert property (s_known ##0 (ref_pulse && !fb_pulse && pulse_count < ptl) |=>
    pulse_count == $past(pulse_count) + 1) else $error("count up wrong");
  a_count_down: assert property (fb_pulse && !ref_pulse && pulse_count != '0 |=>
    pulse_count == $past(pulse_count) - 1) else $error("count down wrong");
  a_count_hold: assert property (ref_pulse == fb_pulse |=> $stable(pulse_count)) else $error("count moved");
  a_floor_zero: assert property (fb_pulse && pulse_count == '0 |=> pulse_count == '0) else $error("below zero");
  a_sat_hold: assert property (s_known ##0 (ref_pulse && pulse_count == ptl) |=> pulse_count == ptl)
    else $error("saturation lost");
  a_cmd_prop: assert property (s_known ##0 ($past(limit_set) == '1) |-> cur_cmd == $past(pulse_count) * 1440 / ptl)
    else $error("command scale wrong");
  a_limit_flag: assert property (s_known ##0 (pulse_count >= ptl) |=> cur_limit) else $error("no limit flag");
  a_limit_zero: assert property ((limit_set == '0) [*2] |-> cur_cmd == '0) else $error("current at zero limit");
  a_gate_trip: assert property (s_trip |=> !pwm_gate && cur_limit) else $error("pulse not curtailed");
endmodule // pbr_chk
bind pbr_regulator pbr_chk #(.CNT_WIDTH(CNT_WIDTH), .GAIN_WIDTH(GAIN_WIDTH), .LIM_WIDTH(LIM_WIDTH),
  .CUR_WIDTH(CUR_WIDTH)) i_pbr_chk (.clk, .sys_rst, .ref_pulse, .fb_pulse, .pwm_start, .pwm_gate,
  .cur_limit, .gain_set, .limit_set, .cur_peak, .cur_cmd, .pulse_count, .fb_revs);

// *** dv/tb.sv ***
// Self-checking bench for the regulator
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t got %0d want %0d", $time, a, b); end end
module tb;
  logic        clk = 1'b0, sys_rst = 1'b1, pwm_start = 1'b0, ref_pulse, fb_pulse, pwm_gate, cur_limit;
  logic [7:0]  gain_set = 8'h00, limit_set = 8'hff, pulse_count;
  logic [11:0] cur_peak, cur_cmd;
  logic [15:0] fb_revs;
  logic [1:0]  mode = 2'h0;
  int          n_errors = 0, n_checks = 0, cnt = 0, cmd = 0, fbs = 0, cyc = 0, ptl, lim;
  int          gate = 0, lmt = 0, hit = 0;
  pbr_regulator i_pbr_regulator (.clk, .sys_rst, .ref_pulse, .fb_pulse, .gain_set, .limit_set, .pwm_start,
    .cur_peak, .cur_cmd, .pwm_gate, .cur_limit, .pulse_count, .fb_revs);
  pbr_motor i_pbr_motor (.clk, .pwm_gate, .mode, .ref_pulse, .fb_pulse, .cur_peak);
  // Pulses to limit fall linearly from 90 at minimum gain to 10 at maximum
  assign ptl = 90 - (gain_set * 80) / 255;
  assign lim = (limit_set == 8'hff) ? 1440 : 0;
  initial forever #12.5 clk = ~clk;
  // ==========================================
  // Reference model, updated on the same edge as the design
  always @(posedge clk) begin
    if (sys_rst) begin cnt = 0; cmd = 0; fbs = 0; gate = 0; lmt = 0; end
    else begin
      hit = gate && (cur_peak >= lim);
      lmt = (cnt >= ptl) || hit;
      cmd = cnt * lim / ptl;
      if (pwm_start) gate = (cmd != 0);
      else if (hit) gate = 0;
      fbs += fb_pulse;
      if (ref_pulse && !fb_pulse) cnt = (cnt >= ptl) ? ptl : cnt + 1;
      else if (fb_pulse && !ref_pulse && cnt > 0) cnt--;
    end
  end
  always @(negedge clk) begin
    cyc++;
    pwm_start = (cyc % 16 == 0);
    if (!sys_rst) begin
      `CHK(pulse_count, cnt)
      `CHK(cur_cmd, cmd)
      `CHK(pwm_gate, gate)
      `CHK(cur_limit, lmt)
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin #150000; n_errors++; test_done; end
  // Gain switched only once drained, so no snap-down case
  initial begin
    void'($urandom(15500));
    repeat (2) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    mode = 2'h1; repeat (300) @(negedge clk);
    mode = 2'h3; repeat (500) @(negedge clk);
    mode = 2'h2; repeat (400) @(negedge clk);
    gain_set = 8'h80;
    mode = 2'h1; repeat (100) @(negedge clk);
    mode = 2'h3; repeat (200) @(negedge clk);
    mode = 2'h2; repeat (300) @(negedge clk);
    gain_set = 8'hff;
    mode = 2'h1; repeat (100) @(negedge clk);
    mode = 2'h3; repeat (500) @(negedge clk);
    limit_set = 8'h00; repeat (100) @(negedge clk);
    mode = 2'h0; repeat (4) @(negedge clk);
    `CHK(fb_revs, fbs / 120)
    test_done;
  end
endmodule // tb
